//--- src/sre_pkg.sv
package sre_pkg;
    // Clock period in picoseconds (125 MHz)
    localparam int CLK_PERIOD_PS    = 8000;
    // Device timing figures in picoseconds
    localparam int T_RC_PS          = 45000;
    localparam int T_AA_PS          = 45000;
    localparam int T_DOE_PS         = 22000;
    localparam int T_HZOE_PS        = 18000;
    localparam int T_PWE_PS         = 35000;
    localparam int T_SD_PS          = 25000;
    localparam int T_HZWE_PS        = 18000;
    localparam int T_WC_PS          = 45000;
    // Least times round up
    localparam int READ_CYC   = (T_AA_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WRITE_CYC  = ((T_HZWE_PS + T_SD_PS > T_PWE_PS ? T_HZWE_PS + T_SD_PS : T_PWE_PS)
                                 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TURN_CYC   = (T_HZOE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W      = 4;
    localparam logic [CNT_W-1:0] CNT_ZERO  = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE   = 4'h1;
    localparam logic [CNT_W-1:0] READ_CNT  = 4'(READ_CYC);
    localparam logic [CNT_W-1:0] WRITE_CNT = 4'(WRITE_CYC);
    localparam logic [CNT_W-1:0] TURN_CNT  = 4'(TURN_CYC);
    localparam int ADDR_W     = 20;
    localparam int DATA_W     = 16;
    localparam int LANE_W     = 8;
    typedef enum logic [2:0] {
        SRE_IDLE,
        SRE_SETUP,
        SRE_READ,
        SRE_WRITE,
        SRE_RECOVER
    } sre_state_type;
endpackage

//--- src/sre_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module sre_pin_sync
    import sre_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             reset_n,
    // Pins and synchronised copy
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] first_reg;
    logic [WIDTH-1:0] second_reg;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            first_reg  <= '0;
            second_reg <= '0;
        end else begin
            first_reg  <= pin_in;
            second_reg <= first_reg;
        end
    end

    assign pin_sync = second_reg;
endmodule
`default_nettype wire

//--- src/sre_host.sv
// Function
// - Read holds select, output drive, a lane enabled, strobe inactive.
// - Address is stable before the select goes active.
// - Data is captured at the ending edge; host holds it across it.
// - Host never drives data while the device may drive it.
// - Strobe pulse with output drive on covers turnoff plus data setup.
`timescale 1ns/10ps
`default_nettype none
module sre_host
    import sre_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              reset_n,
    // User request
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic              req_write,
    input  wire logic [AW:0]       req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    input  wire logic [1:0]        req_lane_n,
    // User answer
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    output logic                   rsp_corrected,
    // Static width choice
    input  wire logic              word_mode,
    // Memory pins
    output logic [AW:0]            mem_addr,
    output logic                   select_low_active,
    output logic                   select_high_active,
    output logic                   write_strobe_n,
    output logic                   out_drive_n,
    output logic                   upper_lane_en_n,
    output logic                   lower_lane_en_n,
    output logic                   width_sel,
    input  wire logic [DATA_W-1:0] mem_data_in,
    output logic [DATA_W-1:0]      mem_data_out,
    output logic [DATA_W-1:0]      mem_data_oe,
    input  wire logic              corr_flag_in
);
    sre_state_type          state_reg, state_next;
    logic [CNT_W-1:0]       cnt_reg, cnt_next;
    logic                   wr_reg, wr_next;
    logic [AW:0]            addr_reg, addr_next;
    logic [DATA_W-1:0]      wdata_reg, wdata_next;
    logic [1:0]             lane_reg, lane_next;
    logic                   sel_reg, sel_next;
    logic                   strobe_reg, strobe_next;
    logic                   drive_reg, drive_next;
    logic                   rvalid_reg, rvalid_next;
    logic [DATA_W-1:0]      rdata_reg, rdata_next;
    logic                   corr_reg, corr_next;
    logic [DATA_W:0]        pins_sync;

    // Read data and flag are asynchronous to our clock
    sre_pin_sync #(.WIDTH(DATA_W + 1)) u_sync (
        .clock    (clock),
        .reset_n  (reset_n),
        .pin_in   ({corr_flag_in, mem_data_in}),
        .pin_sync (pins_sync)
    );

    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        wr_next     = wr_reg;
        addr_next   = addr_reg;
        wdata_next  = wdata_reg;
        lane_next   = lane_reg;
        sel_next    = sel_reg;
        strobe_next = strobe_reg;
        drive_next  = drive_reg;
        rvalid_next = 1'b0;
        rdata_next  = rdata_reg;
        corr_next   = corr_reg;
        case (state_reg)
            SRE_IDLE: begin
                if (req_valid) begin
                    // Address settles one cycle before select goes active
                    addr_next  = req_addr;
                    wr_next    = req_write;
                    wdata_next = word_mode ? req_wdata
                                           : {{LANE_W{1'b0}}, req_wdata[LANE_W-1:0]};
                    lane_next  = word_mode ? req_lane_n : '0;
                    state_next = SRE_SETUP;
                end
            end
            SRE_SETUP: begin
                sel_next = 1'b1;
                if (wr_reg) begin
                    strobe_next = 1'b1;
                    cnt_next    = WRITE_CNT;
                    state_next  = SRE_WRITE;
                end else begin
                    drive_next = 1'b1;
                    cnt_next   = READ_CNT + TURN_CNT;
                    state_next = SRE_READ;
                end
            end
            SRE_READ: begin
                cnt_next = cnt_reg - CNT_ONE;
                if (cnt_reg == CNT_ONE) begin
                    rvalid_next = 1'b1;
                    rdata_next  = pins_sync[DATA_W-1:0];
                    corr_next   = pins_sync[DATA_W];
                    sel_next    = 1'b0;
                    drive_next  = 1'b0;
                    cnt_next    = TURN_CNT;
                    state_next  = SRE_RECOVER;
                end
            end
            SRE_WRITE: begin
                cnt_next = cnt_reg - CNT_ONE;
                if (cnt_reg == CNT_ONE) begin
                    // Strobe rises first; select and data stay one more cycle
                    strobe_next = 1'b0;
                    cnt_next    = CNT_ONE;
                    state_next  = SRE_RECOVER;
                end
            end
            SRE_RECOVER: begin
                sel_next = 1'b0;
                cnt_next = cnt_reg - CNT_ONE;
                if (cnt_reg == CNT_ONE || cnt_reg == CNT_ZERO) begin
                    wr_next    = 1'b0;
                    cnt_next   = CNT_ZERO;
                    state_next = SRE_IDLE;
                end
            end
            default: state_next = SRE_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_reg  <= SRE_IDLE;
            cnt_reg    <= CNT_ZERO;
            wr_reg     <= 1'b0;
            addr_reg   <= '0;
            wdata_reg  <= '0;
            lane_reg   <= '1;
            sel_reg    <= 1'b0;
            strobe_reg <= 1'b0;
            drive_reg  <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            corr_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            wr_reg     <= wr_next;
            addr_reg   <= addr_next;
            wdata_reg  <= wdata_next;
            lane_reg   <= lane_next;
            sel_reg    <= sel_next;
            strobe_reg <= strobe_next;
            drive_reg  <= drive_next;
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            corr_reg   <= corr_next;
        end
    end

    assign req_ready          = (state_reg == SRE_IDLE);
    assign rsp_valid          = rvalid_reg;
    assign rsp_rdata          = rdata_reg;
    assign rsp_corrected      = corr_reg;
    assign mem_addr           = addr_reg;
    assign select_low_active  = ~sel_reg;
    assign select_high_active = sel_reg;
    assign write_strobe_n     = ~strobe_reg;
    assign out_drive_n        = ~drive_reg;
    // Lanes held off outside an access puts the part in standby
    assign upper_lane_en_n    = sel_reg ? lane_reg[1] : 1'b1;
    assign lower_lane_en_n    = sel_reg ? lane_reg[0] : 1'b1;
    assign width_sel          = word_mode;
    assign mem_data_out       = wdata_reg;
    // Drive only during a write, never alongside output drive
    assign mem_data_oe        = {DATA_W{wr_reg && sel_reg && !drive_reg}};

    AST_NO_CONTENTION: assert property (@(posedge clock) disable iff (!reset_n)
        !(drive_reg && |mem_data_oe)) else $error("host drives data while device drives");

    // Device needs its turnoff time before the host may drive the lines again
    sequence bus_quiet;
        (mem_data_oe == '0) [*3];
    endsequence
    AST_TURN_QUIET: assert property (@(posedge clock) disable iff (!reset_n)
        $fell(drive_reg) |-> bus_quiet) else $error("host drives during bus turnaround");

    AST_ADDR_BEFORE_SEL: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(sel_reg) |-> $stable(addr_reg)) else $error("address moved at select");

    // Six cycles cover turnoff plus data setup while output drive may stay on
    sequence write_pulse;
        strobe_reg [*6];
    endsequence
    AST_WRITE_WIDTH: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(strobe_reg) |-> write_pulse) else $error("write pulse too short");

    AST_WRITE_QUAL: assert property (@(posedge clock) disable iff (!reset_n)
        strobe_reg |-> sel_reg && !(upper_lane_en_n && lower_lane_en_n)) else $error("bad write");

    AST_DATA_HOLD: assert property (@(posedge clock) disable iff (!reset_n)
        $fell(strobe_reg) |-> sel_reg && |mem_data_oe && $stable(wdata_reg))
        else $error("data not held at write end");

    AST_READ_QUAL: assert property (@(posedge clock) disable iff (!reset_n)
        drive_reg |-> sel_reg && !strobe_reg) else $error("bad read qualifiers");

    AST_READ_DONE: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(drive_reg) |-> ##[1:20] rsp_valid) else $error("read never answered");

    AST_BYTE_LANES: assert property (@(posedge clock) disable iff (!reset_n)
        (!word_mode && strobe_reg) |-> wdata_reg[DATA_W-1:LANE_W] == '0)
        else $error("byte write high lane not clear");
endmodule
`default_nettype wire

//--- testbench/sre_sram_model.sv
`timescale 1ns/10ps
`default_nettype none
module sre_sram_model
    import sre_pkg::*;
(
    // Memory pins
    input  wire logic [ADDR_W:0]   mem_addr,
    input  wire logic              select_low_active,
    input  wire logic              select_high_active,
    input  wire logic              write_strobe_n,
    input  wire logic              out_drive_n,
    input  wire logic              upper_lane_en_n,
    input  wire logic              lower_lane_en_n,
    input  wire logic              width_sel,
    input  wire logic [DATA_W-1:0] host_data,
    input  wire logic [DATA_W-1:0] host_oe,
    output logic      [DATA_W-1:0] dev_data,
    output logic                   corr_flag
);
    logic [DATA_W-1:0] store [int];
    logic [DATA_W-1:0] check [int];
    int                contention = 0;
    int                addr_moves = 0;
    int                short_pulses = 0;
    logic              toggle = 1'b0;
    logic              armed = 1'b0;
    logic              sel, wr_act, rd_act;
    logic [DATA_W-1:0] drv, word, rdata, seen, wr_data, merged;
    logic [1:0]        wr_lane;
    logic              wr_byte;
    int                idx, wr_idx;
    realtime           wr_start, addr_time, sel_time;
    // Released lines show a moving pattern, never the last value
    always #4 toggle = ~toggle;
    assign idx = int'(mem_addr[ADDR_W-1:0]);
    assign sel = !select_low_active && select_high_active
                 && !(width_sel && upper_lane_en_n && lower_lane_en_n);
    assign wr_act = sel && !write_strobe_n
                    && (!width_sel || !upper_lane_en_n || !lower_lane_en_n);
    assign rd_act = sel && write_strobe_n && !out_drive_n;
    assign drv = width_sel ? {{8{rd_act && !upper_lane_en_n}}, {8{rd_act && !lower_lane_en_n}}}
                           : {8'h00, {8{rd_act}}};
    always @* begin
        word = check.exists(idx) ? check[idx] : 16'h0000;
        rdata = width_sel ? word : {8'h00, mem_addr[ADDR_W] ? word[15:8] : word[7:0]};
        for (int i = 0; i < DATA_W; i++) begin
            dev_data[i] = drv[i] ? rdata[i] : toggle ^ i[0];
            seen[i] = host_oe[i] ? host_data[i] : toggle;
        end
        corr_flag = rd_act ? (store.exists(idx) && store[idx] !== check[idx]) : toggle;
    end
    always @* begin
        if (wr_act) begin
            wr_data = seen;
            wr_lane = {upper_lane_en_n, lower_lane_en_n};
            wr_idx = idx;
            wr_byte = mem_addr[ADDR_W];
        end
    end
    always @(posedge wr_act) begin
        wr_start = $realtime;
        armed = 1'b1;
    end
    // Data at the ending edge is stored; check copy plays the part of the code bits
    always @(negedge wr_act) begin
        if (armed) begin
            merged = check.exists(wr_idx) ? check[wr_idx] : 16'h0000;
            if (!width_sel && wr_byte) merged[15:8] = wr_data[7:0];
            if (!width_sel && !wr_byte) merged[7:0] = wr_data[7:0];
            if (width_sel && !wr_lane[1]) merged[15:8] = wr_data[15:8];
            if (width_sel && !wr_lane[0]) merged[7:0] = wr_data[7:0];
            store[wr_idx] = merged;
            check[wr_idx] = merged;
            if ($realtime - wr_start < (out_drive_n ? T_PWE_PS : T_HZWE_PS + T_SD_PS) / 1000.0)
                short_pulses++;
        end
    end
    always @(drv or host_oe) if (|(drv & host_oe)) contention++;
    always @(mem_addr) begin
        addr_time = $realtime;
        if (wr_act) addr_moves++;
    end
    // Pins have no delay here, so an address change in the select's own step is late
    always @(posedge sel) begin
        sel_time = $realtime;
        #1;
        if (addr_time >= sel_time) addr_moves++;
    end
    task automatic flip(input int i, input int b);
        store[i][b] = ~store[i][b];
    endtask
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import sre_pkg::*;
;
    logic              clock = 1'b0, reset_n = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    logic              word_mode = 1'b1;
    logic [ADDR_W:0]   req_addr = 21'h000000;
    logic [15:0]       req_wdata = 16'h0000, rsp_rdata, mem_in, mem_out, mem_oe, q;
    logic [1:0]        req_lane_n = 2'h0;
    logic              req_ready, rsp_valid, rsp_corrected, c, sl, sh, wsn, odn, un, ln, wsel, cf;
    logic [ADDR_W:0]   mem_addr;
    int                fails = 0;
    int                checks_done = 0;
    always #4 clock = ~clock;
    sre_host dut (.clock(clock), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_lane_n(req_lane_n), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .rsp_corrected(rsp_corrected), .word_mode(word_mode), .mem_addr(mem_addr),
        .select_low_active(sl), .select_high_active(sh), .write_strobe_n(wsn),
        .out_drive_n(odn), .upper_lane_en_n(un), .lower_lane_en_n(ln), .width_sel(wsel),
        .mem_data_in(mem_in), .mem_data_out(mem_out), .mem_data_oe(mem_oe), .corr_flag_in(cf));
    sre_sram_model mdl (.mem_addr(mem_addr), .select_low_active(sl), .select_high_active(sh),
        .write_strobe_n(wsn), .out_drive_n(odn), .upper_lane_en_n(un), .lower_lane_en_n(ln),
        .width_sel(wsel), .host_data(mem_out), .host_oe(mem_oe), .dev_data(mem_in),
        .corr_flag(cf));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic do_req(input logic w, input logic [ADDR_W:0] a, input logic [15:0] d,
                          input logic [1:0] l);
        @(negedge clock);
        while (req_ready !== 1'b1) @(negedge clock);
        @(posedge clock);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        req_lane_n <= l;
        @(posedge clock);
        req_valid <= 1'b0;
    endtask
    task automatic do_read(input logic [ADDR_W:0] a, input logic [1:0] l);
        int n;
        n = 0;
        do_req(1'b0, a, 16'h0000, l);
        while (rsp_valid !== 1'b1 && n < 40) begin
            @(negedge clock);
            n++;
        end
        chk("read latency", 16'(2 + READ_CYC + TURN_CYC), 16'(n));
        q = rsp_rdata;
        c = rsp_corrected;
    endtask
    task automatic t_word;
        int n;
        n = 0;
        do_req(1'b1, 21'h000123, 16'hBEEF, 2'h0);
        // Look only after the take edge has settled, so the busy state is seen
        do begin
            @(negedge clock);
            n++;
        end while (req_ready !== 1'b1 && n < 40);
        chk("write busy cycles", 16'(WRITE_CYC + 3), 16'(n));
        do_read(21'h000123, 2'h0);
        chk("word data", 16'hBEEF, q);
        chk("clean flag", 16'h0000, {15'h0000, c});
        $display("word test done");
    endtask
    task automatic t_lane;
        do_req(1'b1, 21'h000123, 16'h1234, 2'h1);
        do_read(21'h000123, 2'h0);
        chk("upper lane write", 16'h12EF, q);
        do_read(21'h000123, 2'h2);
        chk("lower lane read", 16'h00EF, {8'h00, q[7:0]});
        $display("lane test done");
    endtask
    task automatic t_ecc;
        mdl.flip(32'h123, 3);
        do_read(21'h000123, 2'h0);
        chk("corrected data", 16'h12EF, q);
        chk("corrected flag", 16'h0001, {15'h0000, c});
        $display("correction test done");
    endtask
    task automatic t_byte;
        @(posedge clock);
        word_mode <= 1'b0;
        do_req(1'b1, 21'h000040, 16'hFF3C, 2'h3);
        do_req(1'b1, 21'h100040, 16'h00C3, 2'h3);
        do_read(21'h000040, 2'h3);
        chk("byte low", 16'h003C, {8'h00, q[7:0]});
        do_read(21'h100040, 2'h3);
        chk("byte high", 16'h00C3, {8'h00, q[7:0]});
        chk("width pin", 16'h0000, {15'h0000, wsel});
        $display("byte test done");
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        t_word;
        t_lane;
        t_ecc;
        t_byte;
        chk("bus contention", 16'h0000, 16'(mdl.contention));
        chk("address moves", 16'h0000, 16'(mdl.addr_moves));
        chk("short strobes", 16'h0000, 16'(mdl.short_pulses));
        close_out;
    end
    // About ten transfers of under twenty cycles each
    initial begin
        repeat (5000) @(posedge clock);
        fails++;
        close_out;
    end
endmodule
`default_nettype wire
